/* File: logic/usb_periph_host_bus_port.sv */
// Host parallel port and DMA slave handshake of a USB peripheral controller
// Functional notes
// R01: In muxed mode, latch bit-0 line as command/data select on latch-strobe fall.
// R02: Muxed data phase: drive bit-0 line on reads, capture it on writes.
// R03: Separate bus: command/data select input high means command, low data.
// R04: Host ties select input low in muxed mode; device ignores it.
// R05: Host ties latch strobe low with separate buses; no latching.
// R06: Sixteen-line data bus, driven on reads, sampled on writes.
// R07: Active end-of-transfer input terminates the running DMA transfer.
// R08: DMA request output, programmable polarity, asserted when a transfer is needed.
// R09: DMA controller asserts grant, programmable polarity, to start the transfer.
// R10: Interrupt output active high or low, level or pulse, by configuration.
// R11: Low reset input resets the device asynchronously.
// R12: Two static shape selector inputs set bus width and sharing.
// R13: Shape 0: sixteen-bit host port shared with sixteen-bit DMA port.
// R14: Shape 2: eight-bit shared port; shape 3 reserved, never used.
// R15: Host access only while chip select and its strobe are both asserted.
// R16: Data drivers off except selected host read or device-to-host DMA.
`timescale 1ns/1ps
`include "host_port_defines.svh"
module usb_periph_host_bus_port import host_port_pkg::*; #(
	parameter int DATA_W = `DATA_WIDTH
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Host bus strobes, pin levels
	input  wire logic        cs_n_in,
	input  wire logic        rd_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        ale_in,
	input  wire logic        cmd_data_select_in,
	// Data lines 15..1 and the shared bit-0 line
	input  wire logic [15:1] data_in,
	output logic      [15:1] data_out,
	output logic      [15:1] data_oe_out,
	input  wire logic        muxed_bit0_line_in,
	output logic             muxed_bit0_line_out,
	output logic             muxed_bit0_line_oe_out,
	// DMA handshake pins
	output logic             dma_want_out,
	input  wire logic        dma_grant_in,
	input  wire logic        dma_finish_in,
	// Static configuration
	input  wire logic        bus_shape_sel_lo_in,
	input  wire logic        bus_shape_sel_hi_in,
	input  wire logic        mux_mode_in,
	input  wire logic        want_pol_in,
	input  wire logic        grant_pol_in,
	input  wire logic        finish_pol_in,
	input  wire logic        int_pol_in,
	input  wire logic        int_pulse_in,
	// Interrupt pin
	output logic             int_out,
	// Core side: host accesses
	output logic             host_rd_out,
	output logic             host_wr_out,
	output logic             host_cmd_out,
	output logic      [15:0] host_wdata_out,
	input  wire logic [15:0] host_rd_data_in,
	// Core side: DMA
	input  wire logic        dma_need_in,
	output logic             dma_rd_out,
	output logic             dma_wr_out,
	output logic             dma_done_out,
	input  wire logic [15:0] dma_rd_data_in,
	input  wire logic        irq_in,
	output logic             shape_bad_out
);
	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	pin_sample_if smp ();

	pin_sampler #(.WIDTH(`SAMPLE_WIDTH)) u_sampler (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.raw_in   ({~cs_n_in, ~rd_n_in, ~wr_n_in, ale_in, cmd_data_select_in, muxed_bit0_line_in,
		            data_in, dma_finish_in, dma_grant_in, bus_shape_sel_hi_in, bus_shape_sel_lo_in}),
		.smp      (smp.producer)
	);

	// Only the sixteen-line bus is built; the narrow shape masks it
	if (DATA_W != `DATA_WIDTH) begin : g_bad_width
		$error("data width must be sixteen");
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	port_state_t s_q;
	port_state_t s_d;
	bus_shape_t  shape;
	logic        shape_ok;
	logic        narrow;
	logic        grant;
	logic        finish;
	logic        host_rd_now;
	logic        host_wr_now;
	logic        dma_rd_now;
	logic        dma_wr_now;
	logic        rd_start;
	logic        wr_start;
	logic        cmd_now;
	logic [15:0] mask;
	logic [15:0] pins;

	assign shape    = bus_shape_t'(smp.shape);                                // [R12]
	assign shape_ok = (shape != SHAPE_RSVD3);                                  // [R14]
	assign narrow   = (shape == SHAPE_NARROW8);                                // [R13] [R14]
	assign mask     = narrow ? `NARROW_MASK : 16'hffff;
	assign grant    = (smp.gnt == grant_pol_in) && shape_ok;                  // [R09]
	assign finish   = (smp.fin == finish_pol_in);
	// DMA cycles use grant as their select; host cycles need chip select
	assign host_rd_now = smp.cs && smp.rd && shape_ok && !grant;              // [R15]
	assign host_wr_now = smp.cs && smp.wr && shape_ok && !grant;              // [R15]
	assign dma_rd_now  = grant && s_q.dma_act && smp.rd;
	assign dma_wr_now  = grant && s_q.dma_act && smp.wr;
	assign rd_start    = (host_rd_now || dma_rd_now) && !s_q.rd_act;
	assign wr_start    = (host_wr_now || dma_wr_now) && !s_q.wr_act;
	// Select pin is ignored in muxed mode; latched value used instead
	assign cmd_now     = (!mux_mode_in && (rd_start || wr_start)) ? smp.sel : s_q.cmd; // [R03] [R04]
	assign pins        = {smp.data, smp.bit0} & mask;                          // [R02] [R06]

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.host_wr  = 1'b0;
		s_d.dma_wr   = 1'b0;
		s_d.dma_done = 1'b0;
		s_d.ale_prev = smp.ale;
		s_d.cmd      = cmd_now;
		if (mux_mode_in && s_q.ale_prev && !smp.ale)
			s_d.cmd = smp.bit0;                                                // [R01]
		// Read data is frozen at the start so the bus stays stable
		s_d.rd_act = host_rd_now || dma_rd_now;
		if (rd_start)
			s_d.rdata = (dma_rd_now ? dma_rd_data_in : host_rd_data_in) & mask; // [R06]
		s_d.drive  = host_rd_now || dma_rd_now;                                // [R16]
		// Write data is taken in every active cycle, passed on at the end
		s_d.wr_act = host_wr_now || dma_wr_now;
		if (host_wr_now || dma_wr_now) begin
			s_d.wdata  = pins;                                                 // [R02]
			s_d.wr_dma = dma_wr_now;
		end
		if (s_q.wr_act && !(host_wr_now || dma_wr_now)) begin
			s_d.host_wr = !s_q.wr_dma;
			s_d.dma_wr  = s_q.wr_dma;
		end
		// DMA handshake
		if (grant && s_q.want)
			s_d.dma_act = 1'b1;
		if (s_q.dma_act && finish) begin
			s_d.dma_act  = 1'b0;                                               // [R07]
			s_d.dma_done = 1'b1;
		end
		s_d.want = dma_need_in && !s_d.dma_act && shape_ok;                   // [R08]
		// Interrupt: level follows the source, pulse marks its rise
		s_d.irq_prev = irq_in;
		s_d.int_act  = int_pulse_in ? (irq_in && !s_q.irq_prev) : irq_in;      // [R10]
	end

	// Reset acts without the clock
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			s_q <= `STATE_RESET;                                               // [R11]
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign data_out               = s_q.rdata[15:1];
	assign data_oe_out            = {{8{s_q.drive && !narrow}}, {7{s_q.drive}}}; // [R14] [R16]
	assign muxed_bit0_line_out    = s_q.rdata[0];                              // [R02]
	assign muxed_bit0_line_oe_out = s_q.drive;
	assign dma_want_out           = s_q.want ~^ want_pol_in;                   // [R08]
	assign int_out                = s_q.int_act ~^ int_pol_in;                 // [R10]
	assign host_rd_out            = rd_start && host_rd_now;
	assign dma_rd_out             = rd_start && dma_rd_now;
	assign host_wr_out            = s_q.host_wr;
	assign dma_wr_out             = s_q.dma_wr;
	assign dma_done_out           = s_q.dma_done;
	assign host_cmd_out           = cmd_now;
	assign host_wdata_out         = s_q.wdata;
	assign shape_bad_out          = !shape_ok;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ale_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R01]
		(mux_mode_in && $fell(smp.ale)) |=> (s_q.cmd == $past(smp.bit0)))
		else $error("select not latched on strobe fall");
	a_rd_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R02]
		(host_rd_out && !narrow) |=> (muxed_bit0_line_oe_out && {data_out, muxed_bit0_line_out} == $past(host_rd_data_in)))
		else $error("read data not driven");
	a_wr_bit0: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R02]
		host_wr_out |-> (host_wdata_out[0] == $past(smp.bit0, 2)))
		else $error("write bit 0 not captured");
	a_sep_select: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R03]
		(!mux_mode_in && host_rd_out) |-> (host_cmd_out == smp.sel))
		else $error("select input not decoded");
	a_cs_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R15]
		(!smp.cs && !s_q.wr_act) |-> !host_rd_out ##1 !host_wr_out)
		else $error("access without chip select");
	a_drive_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R16]
		!(host_rd_now || dma_rd_now) |=> !muxed_bit0_line_oe_out && data_oe_out == 15'h0000)
		else $error("bus driven outside a read");
	a_narrow_hi: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
		narrow |-> (data_oe_out[15:8] == 8'h00))
		else $error("upper byte driven in narrow shape");
	a_rsvd_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
		(shape == SHAPE_RSVD3) |-> !host_rd_out && (dma_want_out != want_pol_in))
		else $error("reserved shape not quiet");
	a_eot_end: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R07]
		(s_q.dma_act && finish) |=> (!s_q.dma_act && dma_done_out))
		else $error("transfer not ended on finish");
	a_want_pol: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R08]
		(dma_need_in && shape_ok && !s_q.dma_act && !(grant && s_q.want)) |=> (dma_want_out == want_pol_in))
		else $error("request not raised");
	a_int_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
		(int_pulse_in && s_q.int_act) |=> !s_q.int_act)
		else $error("interrupt pulse longer than one cycle");
endmodule : usb_periph_host_bus_port

/* File: logic/host_port_defines.svh */
// Constants of the host bus port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define SHAPE_WIDE16   2'h0
`define SHAPE_NARROW8  2'h2
`define SHAPE_RSVD3    2'h3
`define NARROW_MASK    16'h00ff
`define DATA_WIDTH     16
`define SAMPLE_WIDTH   25
`define STATE_RESET    '0
`endif

/* File: logic/host_port_pkg.sv */
// Types of the host bus port
package host_port_pkg;
	typedef enum logic [1:0] {
		SHAPE_WIDE16  = 2'b00,
		SHAPE_SPARE1  = 2'b01,
		SHAPE_NARROW8 = 2'b10,
		SHAPE_RSVD3   = 2'b11
	} bus_shape_t;

	typedef struct packed {
		logic        cmd;
		logic        rd_act;
		logic        wr_act;
		logic        wr_dma;
		logic        ale_prev;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        drive;
		logic        host_wr;
		logic        dma_wr;
		logic        want;
		logic        dma_act;
		logic        dma_done;
		logic        irq_prev;
		logic        int_act;
	} port_state_t;
endpackage : host_port_pkg

/* File: logic/pin_sample_if.sv */
// Synchronised pin levels passed from sampler to port logic
`timescale 1ns/1ps
interface pin_sample_if;
	logic        cs;
	logic        rd;
	logic        wr;
	logic        ale;
	logic        sel;
	logic        bit0;
	logic [15:1] data;
	logic        fin;
	logic        gnt;
	logic [1:0]  shape;
	modport producer (output cs, rd, wr, ale, sel, bit0, data, fin, gnt, shape);
	modport consumer (input cs, rd, wr, ale, sel, bit0, data, fin, gnt, shape);
endinterface : pin_sample_if

/* File: logic/pin_sampler.sv */
// Two-stage synchroniser for all host-side pins
`timescale 1ns/1ps
`include "host_port_defines.svh"
module pin_sampler #(
	parameter int WIDTH = `SAMPLE_WIDTH
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Raw pins, strobes active high already; grant and finish at pin level
	input  wire logic [WIDTH-1:0] raw_in,
	// Sampled levels
	pin_sample_if.producer        smp
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	if (WIDTH != `SAMPLE_WIDTH) begin : g_bad_width
		$error("pin_sampler width must match the pin bundle");
	end

	always_comb begin
		s_d    = s_q;
		s_d.s1 = raw_in;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			s_q <= `STATE_RESET;
		else
			s_q <= s_d;
	end

	// Only the second stage is visible to the port logic
	assign {smp.cs, smp.rd, smp.wr, smp.ale, smp.sel, smp.bit0, smp.data, smp.fin, smp.gnt, smp.shape} = s_q.s2;
endmodule : pin_sampler

/* File: bench/host_cpu_model.sv */
// Host processor and DMA controller model driving the port pins
`timescale 1ns/1ps
module host_cpu_model (
	// Clock and configuration
	input  wire logic        clk_in,
	input  wire logic        mux_in,
	input  wire logic        grant_pol_in,
	input  wire logic        finish_pol_in,
	// Device drive, bit 0 is the shared line
	input  wire logic [15:0] dev_data_in,
	input  wire logic [15:0] dev_oe_in,
	// Pins towards the device
	output logic             cs_n_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	output logic             ale_out,
	output logic             sel_out,
	output logic             grant_out,
	output logic             finish_out,
	output logic [15:0]      bus_out
);
	logic [15:0] hv  = 16'h0000;
	logic        hoe = 1'b0;
	logic        g   = 1'b0;
	logic        f   = 1'b0;

	initial begin
		{cs_n_out, rd_n_out, wr_n_out} = 3'h7;
		ale_out = 1'b0;
		sel_out = 1'b0;
	end

	// Released lines float to the inverse of the last host value
	assign bus_out    = (dev_oe_in & dev_data_in) | (~dev_oe_in & (hoe ? hv : ~hv));
	assign grant_out  = g ? grant_pol_in : ~grant_pol_in;
	assign finish_out = f ? finish_pol_in : ~finish_pol_in;

	task automatic access(input logic wr, input logic cmd, input logic use_cs, input logic [15:0] wd,
		output logic [15:0] rd);
		@(posedge clk_in);
		sel_out <= mux_in ? 1'b0 : cmd;
		if (mux_in) begin
			// Bit 0 must outlast the synchronised latch fall
			hv      <= {15'h0, cmd};
			hoe     <= 1'b1;
			ale_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			ale_out <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		hv  <= wd;
		hoe <= wr;
		{cs_n_out, rd_n_out, wr_n_out} <= {~use_cs, wr, ~wr};
		repeat (5) @(posedge clk_in);
		rd = bus_out;
		{cs_n_out, rd_n_out, wr_n_out} <= 3'h7;
		repeat (4) @(posedge clk_in);
		hoe <= 1'b0;
	endtask : access

	task automatic set_grant(input logic v);
		@(posedge clk_in);
		g <= v;
	endtask : set_grant

	task automatic pulse_finish();
		@(posedge clk_in);
		f <= 1'b1;
		repeat (3) @(posedge clk_in);
		f <= 1'b0;
	endtask : pulse_finish
endmodule : host_cpu_model

/* File: bench/testbench.sv */
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module testbench;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        cs_n_in, rd_n_in, wr_n_in, ale_in, cmd_data_select_in, dma_grant_in, dma_finish_in;
	logic [15:0] bus, host_wdata_out, rv, wd_seen;
	logic [15:1] data_out, data_oe_out;
	logic        muxed_bit0_line_out, muxed_bit0_line_oe_out, dma_want_out, int_out, cmd_seen;
	logic        host_rd_out, host_wr_out, host_cmd_out, dma_rd_out, dma_wr_out, dma_done_out, shape_bad_out;
	logic        bus_shape_sel_lo_in = 1'b0, bus_shape_sel_hi_in = 1'b0, mux_mode_in = 1'b0, want_pol_in = 1'b1;
	logic        grant_pol_in = 1'b1, finish_pol_in = 1'b0, int_pol_in = 1'b1, int_pulse_in = 1'b0, irq_in = 1'b0;
	logic        dma_need_in = 1'b0;
	logic [15:0] host_rd_data_in = 16'h0000, dma_rd_data_in = 16'h0000;
	int          err_total = 0, n_compared = 0, rd_cnt = 0, xfer_cnt = 0, done_cnt = 0, k;

	usb_periph_host_bus_port dut (
		.clk_in, .rst_n_in, .cs_n_in, .rd_n_in, .wr_n_in, .ale_in, .cmd_data_select_in,
		.data_in(bus[15:1]), .data_out, .data_oe_out, .muxed_bit0_line_in(bus[0]),
		.muxed_bit0_line_out, .muxed_bit0_line_oe_out, .dma_want_out, .dma_grant_in, .dma_finish_in,
		.bus_shape_sel_lo_in, .bus_shape_sel_hi_in, .mux_mode_in, .want_pol_in, .grant_pol_in, .finish_pol_in,
		.int_pol_in, .int_pulse_in, .int_out, .host_rd_out, .host_wr_out, .host_cmd_out, .host_wdata_out,
		.host_rd_data_in, .dma_need_in, .dma_rd_out, .dma_wr_out, .dma_done_out, .dma_rd_data_in, .irq_in,
		.shape_bad_out
	);

	host_cpu_model host (
		.clk_in, .mux_in(mux_mode_in), .grant_pol_in, .finish_pol_in,
		.dev_data_in({data_out, muxed_bit0_line_out}), .dev_oe_in({data_oe_out, muxed_bit0_line_oe_out}),
		.cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .ale_out(ale_in),
		.sel_out(cmd_data_select_in), .grant_out(dma_grant_in), .finish_out(dma_finish_in), .bus_out(bus)
	);

	initial begin
		forever #50 clk_in = ~clk_in;
	end

	// Core-side pulses are single cycle; looked at mid-cycle where they are settled
	always @(negedge clk_in) begin
		rd_cnt   += int'(host_rd_out === 1'b1);
		xfer_cnt += int'(dma_rd_out === 1'b1) + int'(dma_wr_out === 1'b1);
		done_cnt += int'(dma_done_out === 1'b1);
		if (host_rd_out === 1'b1 || host_wr_out === 1'b1) begin
			cmd_seen = host_cmd_out;
		end
		if (host_wr_out === 1'b1 || dma_wr_out === 1'b1) begin
			wd_seen = host_wdata_out;
		end
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (5000) @(posedge clk_in);
		err_total++;
		end_sim();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		host_rd_data_in <= 16'ha5c3;
		host.access(1'b0, 1'b1, 1'b1, 16'h0000, rv);
		`CHK(rv, 16'ha5c3)
		`CHK(cmd_seen, 1'b1)
		host.access(1'b1, 1'b0, 1'b1, 16'h3c5a, rv);
		`CHK(wd_seen, 16'h3c5a)
		`CHK(cmd_seen, 1'b0)
		host.access(1'b0, 1'b1, 1'b0, 16'h0000, rv);
		`CHK(rd_cnt, 1)
		`CHK({data_oe_out, muxed_bit0_line_oe_out}, 16'h0000)
		mux_mode_in <= 1'b1;
		host_rd_data_in <= 16'h8000;
		host.access(1'b0, 1'b1, 1'b1, 16'h0000, rv);
		`CHK(rv, 16'h8000)
		`CHK(cmd_seen, 1'b1)
		host.access(1'b1, 1'b0, 1'b1, 16'h0001, rv);
		`CHK(wd_seen, 16'h0001)
		`CHK(cmd_seen, 1'b0)
		mux_mode_in <= 1'b0;
		bus_shape_sel_hi_in <= 1'b1;
		host_rd_data_in <= 16'hbeef;
		host.access(1'b0, 1'b0, 1'b1, 16'h0000, rv);
		`CHK(rv[7:0], 8'hef)
		host.access(1'b1, 1'b0, 1'b1, 16'h1234, rv);
		`CHK(wd_seen, 16'h0034)
		bus_shape_sel_lo_in <= 1'b1;
		host.access(1'b0, 1'b0, 1'b1, 16'h0000, rv);
		`CHK(shape_bad_out, 1'b1)
		`CHK(rd_cnt, 3)
		{bus_shape_sel_hi_in, bus_shape_sel_lo_in} <= 2'h0;
		want_pol_in <= 1'b0;
		dma_need_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		`CHK(dma_want_out, 1'b0)
		host.set_grant(1'b1);
		repeat (5) @(posedge clk_in);
		`CHK(dma_want_out, 1'b1)
		dma_need_in <= 1'b0;
		dma_rd_data_in <= 16'h5a0f;
		host.access(1'b0, 1'b0, 1'b0, 16'h0000, rv);
		`CHK(rv, 16'h5a0f)
		host.access(1'b1, 1'b0, 1'b0, 16'h7e81, rv);
		`CHK(wd_seen, 16'h7e81)
		`CHK(xfer_cnt, 2)
		host.pulse_finish();
		repeat (3) @(posedge clk_in);
		`CHK(done_cnt, 1)
		host.set_grant(1'b0);
		int_pol_in <= 1'b0;
		irq_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		`CHK(int_out, 1'b0)
		irq_in <= 1'b0;
		int_pol_in <= 1'b1;
		int_pulse_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		irq_in <= 1'b1;
		k = 0;
		repeat (6) begin
			@(posedge clk_in);
			k += int'(int_out === 1'b1);
		end
		`CHK(k, 1)
		int_pulse_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		`CHK(int_out, 1'b1)
		rst_n_in <= 1'b0;
		#1;
		`CHK(int_out, 1'b0)
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		host.access(1'b0, 1'b1, 1'b1, 16'h0000, rv);
		`CHK(rv, 16'hbeef)
		`CHK(rd_cnt, 4)
		end_sim();
	end
endmodule : testbench
